/* rtl/meh_top.v */
// Purpose: Memory ECC error handler with counting, scrubbing, fault LEDs
// Assumes: One outstanding memory access; memory takes every command
// Notes:   Registers over APB, one wait state on every transfer
// Notes on behaviour
// [R01] Each 64-bit word is stored with an 8-bit Hamming check field.
// [R02] Every read is checked, errors flagged, single-bit errors corrected.
// [R03] Each rank of each channel has its own count against one threshold.
// [R04] Only reaching the threshold raises a reportable event.
// [R05] After the threshold is reached further corrected errors are ignored.
// [R06] Counts shrink as running time passes.
// [R07] Each programmable interval takes one off every nonzero count.
// [R08] Threshold choices are 20, 10, 5, every error, or none.
// [R09] Reaching the threshold logs an event and lights that rank's LED.
// [R10] A detected but uncorrectable read is a fatal error.
// [R11] Fatal errors log, light LED and amber before the machine check.
// [R12] With demand scrub on, corrected reads are written back in place.
// [R13] Demand scrubbing is enabled out of reset.
// [R14] A background patrol reads memory in turn and rewrites correctable words.
`timescale 1ns/1ps
`include "meh_regs.vh"

module meh_top (
   // Clock and reset
   input  wire                   clk_in,
   input  wire                   resetn_in,
   // APB slave
   input  wire                   psel_in,
   input  wire                   penable_in,
   input  wire                   pwrite_in,
   input  wire [7:0]             paddr_in,
   input  wire [31:0]            pwdata_in,
   output reg  [31:0]            prdata_out,
   output reg                    pready_out,
   output reg                    pslverr_out,
   // Controller request path
   input  wire                   req_valid_in,
   input  wire                   req_write_in,
   input  wire [`MEH_ADDR_W-1:0] req_addr_in,
   input  wire [`MEH_DATA_W-1:0] req_wdata_in,
   output reg                    req_ready_out,
   output reg                    rsp_valid_out,
   output reg  [`MEH_DATA_W-1:0] rsp_data_out,
   output reg                    rsp_corr_out,
   output reg                    rsp_uncorr_out,
   // Memory array
   output reg                    mem_cmd_out,
   output reg                    mem_we_out,
   output reg  [`MEH_ADDR_W-1:0] mem_addr_out,
   output reg  [`MEH_CW_W-1:0]   mem_wdata_out,
   input  wire                   mem_rvalid_in,
   input  wire [`MEH_CW_W-1:0]   mem_rdata_in,
   // Fault reporting
   output reg                    log_event_out,
   output reg  [1:0]             log_code_out,
   output reg  [2:0]             log_rank_out,
   output reg  [`MEH_RANKS-1:0]  slot_led_out,
   output reg                    status_amber_out,
   output reg                    machine_check_exception_out,
   output reg                    irq_out
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_BACK = 2'h2;

   reg [1:0]             state_q;
   reg                   own_patrol_q;
   reg [`MEH_ADDR_W-1:0] op_addr_q;
   reg [31:0]            ctrl_q;
   reg [31:0]            leak_ivl_q;
   reg [31:0]            patrol_ivl_q;
   reg [`MEH_INT_W-1:0]  int_stat_q;
   reg [`MEH_INT_W-1:0]  int_mask_q;
   reg [`MEH_ADDR_W-1:0] err_addr_q;
   reg [`MEH_ADDR_W-1:0] patrol_ptr_q;
   reg [31:0]            leak_cnt_q;
   reg [31:0]            patrol_cnt_q;
   reg                   patrol_pend_q;
   reg                   mce_pend_q;

   wire [`MEH_CW_W-1:0]   enc_word;
   wire [`MEH_DATA_W-1:0] dec_data;
   wire                   dec_single;
   wire                   dec_multi;

   // [R01] [R02] Check field and correction
   meh_secded u_codec (
      .enc_data_in    (req_wdata_in),
      .enc_word_out   (enc_word),
      .dec_word_in    (mem_rdata_in),
      .dec_data_out   (dec_data),
      .dec_single_out (dec_single),
      .dec_multi_out  (dec_multi)
   );

   // Decoded data re-encoded for write-back
   wire [`MEH_CW_W-1:0] fix_word;
   meh_secded u_refix (
      .enc_data_in    (dec_data),
      .enc_word_out   (fix_word),
      .dec_word_in    ({`MEH_CW_W{1'b0}}),
      .dec_data_out   (),
      .dec_single_out (),
      .dec_multi_out  ()
   );

   // APB decode
   wire       apb_acc = psel_in & penable_in & pready_out;
   wire       apb_wr  = apb_acc & pwrite_in;
   reg        addr_ok;
   reg [31:0] rd_mux;

   always @* begin
      addr_ok = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr_in)
         `MEH_OFF_CTRL:       rd_mux = ctrl_q;
         `MEH_OFF_LEAK_IVL:   rd_mux = leak_ivl_q;
         `MEH_OFF_PATROL_IVL: rd_mux = patrol_ivl_q;
         `MEH_OFF_INT_STAT:   rd_mux[`MEH_INT_W-1:0] = int_stat_q;
         `MEH_OFF_INT_MASK:   rd_mux[`MEH_INT_W-1:0] = int_mask_q;
         `MEH_OFF_SLOT_FAULT: rd_mux[`MEH_RANKS-1:0] = slot_led_out;
         `MEH_OFF_ERR_ADDR:   rd_mux[`MEH_ADDR_W-1:0] = err_addr_q;
         `MEH_OFF_STATUS:     rd_mux[2:0] = {patrol_pend_q, state_q};
         `MEH_OFF_PATROL_PTR: rd_mux[`MEH_ADDR_W-1:0] = patrol_ptr_q;
         default:             addr_ok = 1'b0;
      endcase
   end

   // One wait state keeps prdata straight from a flop
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= psel_in & penable_in & ~pready_out;
         pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_ok;
         if (psel_in & penable_in & ~pready_out)
            prdata_out <= rd_mux;
      end
   end

   // Threshold value from selector
   reg [`MEH_CNT_W-1:0] thr_val;
   wire [2:0] thr_sel = ctrl_q[`MEH_CTRL_THR_HI:`MEH_CTRL_THR_LO];
   always @* begin
      // [R08] Threshold choices
      case (thr_sel)
         `MEH_THR_20:  thr_val = 5'd20;
         `MEH_THR_10:  thr_val = 5'd10;
         `MEH_THR_5:   thr_val = 5'd5;
         `MEH_THR_ALL: thr_val = 5'd1;
         default:      thr_val = 5'd0;
      endcase
   end

   // Read completion events
   wire rd_done  = (state_q == ST_WAIT) & mem_rvalid_in;
   wire ce_evt   = rd_done & dec_single;
   wire ue_evt   = rd_done & dec_multi;
   wire [2:0] op_rank = op_addr_q[`MEH_RANK_HI:`MEH_RANK_LO];
   // [R12] [R14] Write back when demand scrub is on or patrol found it
   wire do_back  = ce_evt &
                   (own_patrol_q | ctrl_q[`MEH_CTRL_DEMAND]);

   // [R07] Leak interval divider
   wire leak_tick = (leak_ivl_q != 32'h0000_0000) &&
                    (leak_cnt_q >= leak_ivl_q - 32'h0000_0001);
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)
         leak_cnt_q <= 32'h0000_0000;
      else if (leak_tick)
         leak_cnt_q <= 32'h0000_0000;
      else
         leak_cnt_q <= leak_cnt_q + 32'h0000_0001;
   end

   // Per-rank counters
   wire [`MEH_RANKS-1:0] trip_hit;
   genvar g;
   generate
      for (g = 0; g < `MEH_RANKS; g = g + 1) begin : g_rank
         reg [`MEH_CNT_W-1:0] cnt_q;
         wire hit_me = ce_evt && (op_rank == g);
         // [R05] A lit rank no longer counts
         wire inc = hit_me && !slot_led_out[g] && (thr_val != 5'd0);
         // [R06] Leak
         wire dec = leak_tick && (cnt_q != 5'd0);
         // [R04] Report only at threshold
         assign trip_hit[g] = inc && (cnt_q + 5'd1 >= thr_val);
         // [R03] One count per rank
         always @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in)
               cnt_q <= 5'd0;
            else if (inc && !dec)
               cnt_q <= cnt_q + 5'd1;
            else if (dec && !inc)
               cnt_q <= cnt_q - 5'd1;
         end
      end
   endgenerate

   // Patrol timer
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)
         patrol_cnt_q <= 32'h0000_0000;
      else if (!ctrl_q[`MEH_CTRL_PATROL] || patrol_pend_q)
         patrol_cnt_q <= 32'h0000_0000;
      else
         patrol_cnt_q <= patrol_cnt_q + 32'h0000_0001;
   end
   wire patrol_tick = ctrl_q[`MEH_CTRL_PATROL] && !patrol_pend_q &&
                      (patrol_cnt_q >= patrol_ivl_q);

   wire take_host   = (state_q == ST_IDLE) & req_ready_out & req_valid_in;
   wire take_patrol = (state_q == ST_IDLE) & ~take_host & patrol_pend_q;

   // Access sequencer; host traffic beats patrol
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q       <= ST_IDLE;
         own_patrol_q  <= 1'b0;
         op_addr_q     <= {`MEH_ADDR_W{1'b0}};
         patrol_ptr_q  <= {`MEH_ADDR_W{1'b0}};
         patrol_pend_q <= 1'b0;
         req_ready_out <= 1'b0;
         rsp_valid_out <= 1'b0;
         rsp_data_out  <= {`MEH_DATA_W{1'b0}};
         rsp_corr_out  <= 1'b0;
         rsp_uncorr_out <= 1'b0;
         mem_cmd_out   <= 1'b0;
         mem_we_out    <= 1'b0;
         mem_addr_out  <= {`MEH_ADDR_W{1'b0}};
         mem_wdata_out <= {`MEH_CW_W{1'b0}};
      end else begin
         mem_cmd_out   <= 1'b0;
         mem_we_out    <= 1'b0;
         rsp_valid_out <= 1'b0;
         if (patrol_tick)
            patrol_pend_q <= 1'b1;
         case (state_q)
            ST_IDLE: begin
               req_ready_out <= ~take_host & ~take_patrol;
               if (take_host) begin
                  mem_cmd_out  <= 1'b1;
                  mem_addr_out <= req_addr_in;
                  own_patrol_q <= 1'b0;
                  op_addr_q    <= req_addr_in;
                  if (req_write_in) begin
                     // [R01] Store data with check field
                     mem_we_out    <= 1'b1;
                     mem_wdata_out <= enc_word;
                     state_q       <= ST_BACK;
                  end else begin
                     state_q <= ST_WAIT;
                  end
               end else if (take_patrol) begin
                  // [R14] Patrol read of next location
                  mem_cmd_out   <= 1'b1;
                  mem_addr_out  <= patrol_ptr_q;
                  op_addr_q     <= patrol_ptr_q;
                  own_patrol_q  <= 1'b1;
                  patrol_ptr_q  <= patrol_ptr_q + 1'b1;
                  patrol_pend_q <= 1'b0;
                  state_q       <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (mem_rvalid_in) begin
                  // [R02] Return corrected data and flags
                  rsp_valid_out  <= ~own_patrol_q;
                  rsp_data_out   <= dec_data;
                  rsp_corr_out   <= dec_single;
                  rsp_uncorr_out <= dec_multi;
                  if (do_back) begin
                     mem_cmd_out   <= 1'b1;
                     mem_we_out    <= 1'b1;
                     mem_addr_out  <= op_addr_q;
                     mem_wdata_out <= fix_word;
                  end
                  state_q <= ST_BACK;
               end
            end
            ST_BACK: begin
               req_ready_out <= 1'b1;
               state_q       <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Event capture; set beats software clear
   wire [`MEH_INT_W-1:0] int_set;
   assign int_set[`MEH_INT_CE_THR] = |trip_hit;
   assign int_set[`MEH_INT_UE]     = ue_evt;
   assign int_set[`MEH_INT_CORR]   = ce_evt;
   assign int_set[`MEH_INT_SCRUB]  = do_back;
   wire [`MEH_INT_W-1:0] stat_clr =
      (apb_wr && paddr_in == `MEH_OFF_INT_STAT) ?
      pwdata_in[`MEH_INT_W-1:0] : {`MEH_INT_W{1'b0}};
   wire [`MEH_RANKS-1:0] led_clr =
      (apb_wr && paddr_in == `MEH_OFF_SLOT_FAULT) ?
      pwdata_in[`MEH_RANKS-1:0] : {`MEH_RANKS{1'b0}};
   wire [`MEH_RANKS-1:0] ue_led =
      ue_evt ? (8'h01 << op_rank) : 8'h00;

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         // [R13] Demand scrub on from reset
         ctrl_q       <= `MEH_CTRL_RESET;
         leak_ivl_q   <= `MEH_LEAK_RESET;
         patrol_ivl_q <= `MEH_PATROL_RESET;
         int_mask_q   <= {`MEH_INT_W{1'b0}};
         int_stat_q   <= {`MEH_INT_W{1'b0}};
         err_addr_q   <= {`MEH_ADDR_W{1'b0}};
         slot_led_out <= {`MEH_RANKS{1'b0}};
         irq_out      <= 1'b0;
      end else begin
         if (apb_wr && paddr_in == `MEH_OFF_CTRL)
            ctrl_q <= pwdata_in;
         if (apb_wr && paddr_in == `MEH_OFF_LEAK_IVL)
            leak_ivl_q <= pwdata_in;
         if (apb_wr && paddr_in == `MEH_OFF_PATROL_IVL)
            patrol_ivl_q <= pwdata_in;
         if (apb_wr && paddr_in == `MEH_OFF_INT_MASK)
            int_mask_q <= pwdata_in[`MEH_INT_W-1:0];
         int_stat_q <= (int_stat_q & ~stat_clr) | int_set;
         if (ce_evt | ue_evt)
            err_addr_q <= op_addr_q;
         // [R09] [R11] Slot LED lit with the log event
         slot_led_out <= (slot_led_out & ~led_clr) | trip_hit | ue_led;
         irq_out <= |(((int_stat_q & ~stat_clr) | int_set) & int_mask_q);
      end
   end

   // Logging and fatal path
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         log_event_out    <= 1'b0;
         log_code_out     <= 2'h0;
         log_rank_out     <= 3'h0;
         status_amber_out <= 1'b0;
         mce_pend_q       <= 1'b0;
         machine_check_exception_out <= 1'b0;
      end else begin
         log_event_out <= ue_evt | (|trip_hit);
         // [R10] Uncorrectable is fatal
         if (ue_evt) begin
            log_code_out     <= `MEH_LOG_UE;
            log_rank_out     <= op_rank;
            status_amber_out <= 1'b1;
         end else if (|trip_hit) begin
            // [R09] Threshold log event
            log_code_out <= `MEH_LOG_CE_THR;
            log_rank_out <= op_rank;
         end
         // [R11] Machine check one cycle after log, LED, amber
         mce_pend_q <= ue_evt;
         machine_check_exception_out <= mce_pend_q;
      end
   end

endmodule // meh_top

/* rtl/meh_regs.vh */
// Purpose: Offsets, fields, reset values and timing for the ECC handler
// Assumes: APB byte addresses, 32-bit aligned registers
// Notes:   Included by every design file of the block
`ifndef MEH_REGS_VH
`define MEH_REGS_VH

// Register byte offsets
`define MEH_OFF_CTRL       8'h00
`define MEH_OFF_LEAK_IVL   8'h04
`define MEH_OFF_PATROL_IVL 8'h08
`define MEH_OFF_INT_STAT   8'h0C
`define MEH_OFF_INT_MASK   8'h10
`define MEH_OFF_SLOT_FAULT 8'h14
`define MEH_OFF_ERR_ADDR   8'h18
`define MEH_OFF_STATUS     8'h1C
`define MEH_OFF_PATROL_PTR 8'h20

// Control fields
`define MEH_CTRL_DEMAND    0
`define MEH_CTRL_PATROL    1
`define MEH_CTRL_THR_LO    4
`define MEH_CTRL_THR_HI    6
`define MEH_CTRL_RESET     32'h0000_0011

// Threshold selector codes
`define MEH_THR_OFF        3'h0
`define MEH_THR_20         3'h1
`define MEH_THR_10         3'h2
`define MEH_THR_5          3'h3
`define MEH_THR_ALL        3'h4

// Interrupt status bits
`define MEH_INT_CE_THR     0
`define MEH_INT_UE         1
`define MEH_INT_CORR       2
`define MEH_INT_SCRUB      3
`define MEH_INT_W          4

// Log codes
`define MEH_LOG_CE_THR     2'h1
`define MEH_LOG_UE         2'h2

// Geometry
`define MEH_DATA_W         64
`define MEH_CW_W           72
`define MEH_ADDR_W         28
`define MEH_RANK_HI        27
`define MEH_RANK_LO        25
`define MEH_RANKS          8
`define MEH_CNT_W          5

// Timing reset values, in clock cycles
`define MEH_LEAK_RESET     32'h0400_0000
`define MEH_PATROL_RESET   32'h0000_1000

`endif

/* rtl/meh_secded.v */
// Purpose: Hamming SEC-DED codec, 64 data bits in a 72-bit word
// Assumes: Purely combinational; used for both write and read path
// Notes:   Bit 0 holds overall parity, bits 1..71 follow Hamming positions
`timescale 1ns/1ps
`include "meh_regs.vh"

module meh_secded (
   // Encode side
   input  wire [`MEH_DATA_W-1:0] enc_data_in,
   output reg  [`MEH_CW_W-1:0]   enc_word_out,
   // Decode side
   input  wire [`MEH_CW_W-1:0]   dec_word_in,
   output reg  [`MEH_DATA_W-1:0] dec_data_out,
   output reg                    dec_single_out,
   output reg                    dec_multi_out
);

   integer           i;
   integer           k;
   integer           d;
   integer           j;
   integer           m;
   integer           e;
   reg     [6:0]     syn;
   reg               ovr;
   reg [`MEH_CW_W-1:0] fix;

   always @* begin
      enc_word_out = {`MEH_CW_W{1'b0}};
      d = 0;
      for (i = 1; i < `MEH_CW_W; i = i + 1) begin
         if ((i & (i - 1)) != 0) begin
            enc_word_out[i] = enc_data_in[d];
            d = d + 1;
         end
      end
      for (k = 0; k < 7; k = k + 1) begin
         for (i = 1; i < `MEH_CW_W; i = i + 1) begin
            if (((i >> k) & 1) == 1 && i != (1 << k))
               enc_word_out[1 << k] = enc_word_out[1 << k] ^ enc_word_out[i];
         end
      end
      enc_word_out[0] = ^enc_word_out[`MEH_CW_W-1:1];
   end

   always @* begin
      syn = 7'h00;
      for (m = 0; m < 7; m = m + 1) begin
         for (j = 1; j < `MEH_CW_W; j = j + 1) begin
            if (((j >> m) & 1) == 1)
               syn[m] = syn[m] ^ dec_word_in[j];
         end
      end
      ovr = ^dec_word_in;
      fix = dec_word_in;
      dec_single_out = 1'b0;
      dec_multi_out = 1'b0;
      if (ovr && syn < 7'd72) begin
         // Odd weight with a valid position: one flipped bit
         dec_single_out = 1'b1;
         fix[syn] = ~fix[syn];
      end else if (syn != 7'h00) begin
         // Even weight or out-of-range position: beyond correction
         dec_multi_out = 1'b1;
      end
      dec_data_out = {`MEH_DATA_W{1'b0}};
      e = 0;
      for (j = 1; j < `MEH_CW_W; j = j + 1) begin
         if ((j & (j - 1)) != 0) begin
            dec_data_out[e] = fix[j];
            e = e + 1;
         end
      end
   end

endmodule // meh_secded

/* sim/meh_top_assertions.sv */
// Purpose: Port-level checks for the ECC error handler
// Assumes: Bound into meh_top; one memory access in flight
// Notes:   Keeps last read address
`timescale 1ns/1ps
`include "meh_regs.vh"

module meh_chk (
   input logic                   clk_in,
   input logic                   resetn_in,
   input logic                   mem_rvalid_in,
   input logic                   rsp_valid_out,
   input logic                   rsp_corr_out,
   input logic                   rsp_uncorr_out,
   input logic                   mem_cmd_out,
   input logic                   mem_we_out,
   input logic [`MEH_ADDR_W-1:0] mem_addr_out,
   input logic                   log_event_out,
   input logic [1:0]             log_code_out,
   input logic [2:0]             log_rank_out,
   input logic [`MEH_RANKS-1:0]  slot_led_out,
   input logic                   status_amber_out,
   input logic                   machine_check_exception_out
);
   logic [`MEH_ADDR_W-1:0] rd_addr_q;
   logic [`MEH_RANKS-1:0]  led_prev_q;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rd_addr_q  <= '0;
         led_prev_q <= '0;
      end else begin
         if (mem_cmd_out && !mem_we_out)
            rd_addr_q <= mem_addr_out;
         led_prev_q <= slot_led_out;
      end
   end

   AST_FLAGS_EXCL: assert property (
      rsp_valid_out |-> !(rsp_corr_out && rsp_uncorr_out))
      else $error("Both read flags set");
   AST_RSP_AFTER_RET: assert property (
      rsp_valid_out |-> $past(mem_rvalid_in))
      else $error("Answer without memory return");
   AST_SCRUB_SAME: assert property (
      rsp_valid_out && mem_cmd_out && mem_we_out
      |-> rsp_corr_out && mem_addr_out == rd_addr_q)
      else $error("Write-back address wrong");
   AST_UE_REPORT: assert property (
      rsp_valid_out && rsp_uncorr_out |-> log_event_out
      && log_code_out == `MEH_LOG_UE && status_amber_out
      && slot_led_out[log_rank_out] ##1 machine_check_exception_out)
      else $error("Fatal read not reported");
   AST_MCE_ORDER: assert property (
      $rose(machine_check_exception_out)
      |-> status_amber_out && $past(log_event_out))
      else $error("Machine check before log and amber");
   AST_AMBER_STICKY: assert property (
      status_amber_out |=> status_amber_out)
      else $error("Amber status dropped");
   AST_CE_LED: assert property (
      log_event_out && log_code_out == `MEH_LOG_CE_THR
      |-> slot_led_out[log_rank_out])
      else $error("Threshold event without LED");
   AST_CE_ONCE: assert property (
      log_event_out && log_code_out == `MEH_LOG_CE_THR
      |-> !led_prev_q[log_rank_out])
      else $error("Repeat threshold event");
   AST_EVT_ON_READ: assert property (
      log_event_out |-> $past(mem_rvalid_in))
      else $error("Event without read return");
endmodule // meh_chk

bind meh_top meh_chk u_chk (.*);

/* sim/meh_mem_model.sv */
// Purpose: Behavioural memory array of 72-bit stored words
// Assumes: One read in flight; writes land at once
// Notes:   Data lines toggle while no read is returned
`timescale 1ns/1ps

module meh_mem_model (
   input  logic        clk_in,
   input  logic        cmd_in,
   input  logic        we_in,
   input  logic [27:0] addr_in,
   input  logic [71:0] wdata_in,
   output logic        rvalid_out,
   output logic [71:0] rdata_out
);
   logic [71:0] arr [256];
   logic [7:0]  ra;
   int          lat = 1;
   int          cnt = 0;

   // Unwritten words read as all zero so patrol sweeps stay quiet
   initial begin
      rvalid_out = 1'b0;
      rdata_out  = '0;
      for (int j = 0; j < 256; j++)
         arr[j] = '0;
   end

   // Address folds to rank and five low bits
   always @(posedge clk_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= ~rdata_out;
      if (cmd_in && we_in)
         arr[{addr_in[27:25], addr_in[4:0]}] = wdata_in;
      if (cmd_in && !we_in) begin
         ra  <= {addr_in[27:25], addr_in[4:0]};
         cnt <= lat;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            rvalid_out <= 1'b1;
            rdata_out  <= arr[ra];
         end
      end
   end
endmodule // meh_mem_model

/* sim/meh_top_bench.sv */
// Purpose: Self-checking bench for the ECC error handler
// Assumes: Model read delay is settable
// Notes:   Stored words are corrupted directly inside the model
`timescale 1ns/1ps
`include "meh_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   error_cnt++; $display("Error %s exp %0h seen %0h", n, e, g); end end
`define WAITC(c) begin wi = 0; do @(posedge clk_in); \
   while (!(c) && ++wi < 2000); `CHK("wait", 1'b1, wi < 2000) \
   if (wi >= 2000) stop_test; end

module meh_top_bench;
   logic        clk_in, resetn_in, psel_in, penable_in, pwrite_in;
   logic        pready_out, pslverr_out, req_valid_in, req_write_in;
   logic        req_ready_out, rsp_valid_out, rsp_corr_out, rsp_uncorr_out;
   logic        mem_cmd_out, mem_we_out, mem_rvalid_in, log_event_out;
   logic        status_amber_out, machine_check_exception_out, irq_out;
   logic        er, hc, hu;
   logic [1:0]  log_code_out;
   logic [2:0]  log_rank_out;
   logic [7:0]  paddr_in, slot_led_out;
   logic [27:0] req_addr_in, mem_addr_out, a;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [63:0] req_wdata_in, rsp_data_out, hd;
   logic [71:0] mem_wdata_out, mem_rdata_in;
   logic [2:0]  codes [5] = '{`MEH_THR_20, `MEH_THR_10, `MEH_THR_5,
                              `MEH_THR_ALL, `MEH_THR_OFF};
   int          lims [5] = '{20, 10, 5, 1, 0};
   int          reads [5] = '{21, 11, 6, 1, 3};
   int          pos [6] = '{0, 1, 7, 63, 64, 71};
   int          error_cnt = 0, check_count = 0, wi, base;
   int          ce_logs = 0, ue_logs = 0, mces = 0, wb2 = 0;

   meh_top dut (.*);
   meh_mem_model mem (
      .clk_in(clk_in), .cmd_in(mem_cmd_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .rvalid_out(mem_rvalid_in), .rdata_out(mem_rdata_in));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   always @(posedge clk_in) begin
      if (log_event_out === 1'b1 && log_code_out === `MEH_LOG_CE_THR)
         ce_logs++;
      if (log_event_out === 1'b1 && log_code_out === `MEH_LOG_UE)
         ue_logs++;
      if (machine_check_exception_out === 1'b1)
         mces++;
      if (mem_cmd_out === 1'b1 && mem_we_out === 1'b1 && mem_addr_out === 28'h2)
         wb2++;
   end

   task stop_test;
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] pa, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= pa;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      `WAITC(pready_out === 1'b1)
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Reads wait for the answer and room for write-back
   task host(input logic w, input logic [27:0] ha, input logic [63:0] d);
      @(posedge clk_in);
      req_valid_in <= 1'b1;
      req_write_in <= w;
      req_addr_in <= ha;
      req_wdata_in <= d;
      `WAITC(req_ready_out === 1'b1)
      req_valid_in <= 1'b0;
      if (!w) begin
         `WAITC(rsp_valid_out === 1'b1)
         hd = rsp_data_out;
         hc = rsp_corr_out;
         hu = rsp_uncorr_out;
      end
      repeat (3) @(posedge clk_in);
   endtask

   task flip(input logic [27:0] fa, input logic [71:0] m);
      mem.arr[{fa[27:25], fa[4:0]}] ^= m;
   endtask

   initial begin
      {resetn_in, psel_in, penable_in, pwrite_in} = '0;
      {req_valid_in, req_write_in, paddr_in, pwdata_in} = '0;
      {req_addr_in, req_wdata_in} = '0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      apb(0, `MEH_OFF_CTRL, 0);
      `CHK("ctrl", `MEH_CTRL_RESET, rd)
      apb(0, 8'h40, 0);
      `CHK("unmapped", 33'h100000000, {er, rd})
      a = 28'h5;
      host(1, a, 64'h0123456789ABCDEF);
      host(0, a, 0);
      `CHK("clean", 66'h00123456789ABCDEF, {hc, hu, hd})
      for (int i = 0; i < 6; i++) begin
         mem.lat = i + 1;
         flip(a, 72'h1 << pos[i]);
         host(0, a, 0);
         `CHK("single", 66'h20123456789ABCDEF, {hc, hu, hd})
      end
      host(0, a, 0);
      `CHK("rewritten", 1'b0, hc)
      apb(0, `MEH_OFF_INT_STAT, 0);
      `CHK("int stat", 32'h0000000C, rd)
      `CHK("irq masked", 1'b0, irq_out)
      apb(1, `MEH_OFF_CTRL, 32'h10);
      flip(a, 72'h10);
      host(0, a, 0);
      host(0, a, 0);
      `CHK("no scrub", 1'b1, hc)
      apb(1, `MEH_OFF_CTRL, `MEH_CTRL_RESET);
      host(0, a, 0);
      host(0, a, 0);
      `CHK("scrub on", 1'b0, hc)
      apb(1, `MEH_OFF_INT_MASK, 32'h1);
      for (int k = 0; k < 5; k++) begin
         a = {3'(k + 1), 25'h10};
         apb(1, `MEH_OFF_CTRL, {25'h0, codes[k], 4'h1});
         host(1, a, 64'h55);
         base = ce_logs;
         for (int i = 1; i <= reads[k]; i++) begin
            flip(a, 72'h8);
            host(0, a, 0);
            `CHK("ce log", lims[k] && i >= lims[k], ce_logs - base)
         end
         `CHK("led", lims[k] != 0, slot_led_out[k + 1])
         `CHK("irq", lims[k] != 0, irq_out)
         apb(1, `MEH_OFF_INT_STAT, 32'hF);
         repeat (2) @(posedge clk_in);
         `CHK("irq clear", 1'b0, irq_out)
      end
      apb(1, `MEH_OFF_CTRL, {25'h0, `MEH_THR_ALL, 4'h1});
      apb(1, `MEH_OFF_SLOT_FAULT, 32'h10);
      base = ce_logs;
      a = {3'd4, 25'h10};
      flip(a, 72'h8);
      host(0, a, 0);
      `CHK("rearm", 1, ce_logs - base)
      apb(1, `MEH_OFF_CTRL, {25'h0, `MEH_THR_5, 4'h1});
      apb(1, `MEH_OFF_LEAK_IVL, 32'h10);
      a = {3'd6, 25'h10};
      host(1, a, 64'h66);
      base = ce_logs;
      for (int i = 0; i < 8; i++) begin
         if (i == 4)
            repeat (200) @(posedge clk_in);
         flip(a, 72'h8);
         host(0, a, 0);
      end
      `CHK("leak", 0, ce_logs - base)
      apb(1, `MEH_OFF_LEAK_IVL, 32'h0);
      a = {3'd7, 25'h10};
      host(1, a, 64'h77);
      flip(a, 72'h300);
      host(0, a, 0);
      `CHK("ue flags", 2'b01, {hc, hu})
      `CHK("ue state", 7'h77, {status_amber_out, slot_led_out[7],
                               log_code_out, log_rank_out})
      `CHK("ue pulses", 2, ue_logs + mces)
      for (int i = 0; i < 4; i++)
         host(1, 28'(i), 64'hA5A5000000000000 | i);
      flip(28'h2, 72'h20);
      wb2 = 0;
      apb(1, `MEH_OFF_PATROL_IVL, 32'h10);
      apb(1, `MEH_OFF_CTRL, 32'h13);
      `WAITC(wb2 > 0)
      apb(1, `MEH_OFF_CTRL, `MEH_CTRL_RESET);
      host(0, 28'h2, 0);
      `CHK("patrol", 66'h0A5A5000000000002, {hc, hu, hd})
      stop_test;
   end
endmodule // meh_top_bench
